// *** logic/fpec_flash_control.sv ***
// Flash program/erase controller: control registers, pulses, verify, protection.
// Assumes CPU strobes are one-cycle and synchronous; resetn_i is the power-on reset.
`timescale 1ns/100ps
module fpec_flash_control
    import fpec_pkg::*;
#(
    parameter int NBLK = fpec_pkg::BLOCKS
) (
    input  wire logic                      clk_i,
    input  wire logic                      resetn_i,
    input  wire logic                      sys_reset_i,
    input  fpec_pkg::fpec_lsi_type         lsi_mode_i,
    input  wire logic                      boot_run_i,
    input  wire logic                      exception_i,
    input  wire logic                      sleep_i,
    input  wire logic                      c1_wr_i,
    input  wire logic [7:0]                c1_wdata_i,
    input  wire logic                      ebs_wr_i,
    input  wire logic [NBLK-1:0]           ebs_wdata_i,
    input  wire logic                      pwr_wr_i,
    input  wire logic [7:0]                pwr_wdata_i,
    input  wire logic                      flash_wr_i,
    input  wire logic                      flash_rd_i,
    input  wire logic [fpec_pkg::ADDR_W-1:0] flash_addr_i,
    input  wire logic [7:0]                flash_wdata_i,
    input  wire logic [31:0]               array_rdata_i,
    input  wire logic [fpec_pkg::PAGE_IW-1:0] page_rd_idx_i,
    output logic [7:0]                     flash_control_one_o,
    output logic [7:0]                     flash_control_two_o,
    output logic [NBLK-1:0]                erase_block_select_o,
    output logic [7:0]                     flash_power_control_o,
    output fpec_pkg::fpec_mode_type        flash_mode_o,
    output logic                           program_pulse_o,
    output logic                           erase_pulse_o,
    output logic [NBLK-1:0]                erase_blocks_o,
    output logic [fpec_pkg::ADDR_W-1:0]    page_addr_o,
    output logic [7:0]                     page_rd_data_o,
    output logic                           irq_block_o,
    output logic                           verify_armed_o,
    output logic [fpec_pkg::ADDR_W-1:0]    verify_addr_o,
    output logic                           verify_valid_o,
    output logic [31:0]                    verify_data_o,
    output fpec_pkg::fpec_fstate_type      flash_state_o
);
    import fpec_pkg::*;

    fpec_page_if #(.AW(ADDR_W), .IW(PAGE_IW)) pg ();

    logic [7:0]        c1_r;
    logic [7:0]        c1_nxt;
    logic              err_r;
    logic              err_nxt;
    logic [NBLK-1:0]   ebs_r;
    logic [NBLK-1:0]   ebs_nxt;
    logic              pds_r;
    logic              pds_nxt;
    fpec_mode_type     mode_r;
    fpec_mode_type     mode_nxt;
    logic              pp_r;
    logic              pp_nxt;
    logic              ep_r;
    logic              ep_nxt;
    logic [NBLK-1:0]   eblk_r;
    logic [NBLK-1:0]   eblk_nxt;
    logic              irqb_r;
    logic              irqb_nxt;
    logic              varm_r;
    logic              varm_nxt;
    logic [ADDR_W-1:0] vaddr_r;
    logic [ADDR_W-1:0] vaddr_nxt;
    logic              vval_r;
    logic              vval_nxt;
    logic [31:0]       vdat_r;
    logic [31:0]       vdat_nxt;
    logic              hw_prot;
    logic              err_evt;
    logic              in_verify;
    logic              dummy_wr;

    always_comb begin
        hw_prot   = sys_reset_i || lsi_mode_i == LSI_SUBACT ||
                    lsi_mode_i == LSI_SUBSLEEP || lsi_mode_i == LSI_STANDBY;
        // Any of the three hazards while a pulse is applied
        err_evt   = (pp_r || ep_r) && (flash_rd_i || exception_i || sleep_i);
        err_nxt   = err_r || err_evt;
        c1_nxt    = c1_r;
        ebs_nxt   = ebs_r;
        pds_nxt   = pds_r;
        if (c1_wr_i) begin
            c1_nxt = c1_wdata_i;
        end
        if (ebs_wr_i) begin
            ebs_nxt = ebs_wdata_i;
        end
        if (pwr_wr_i) begin
            pds_nxt = pwr_wdata_i[PWR_PDS];
        end
        if (hw_prot) begin
            c1_nxt  = C1_RST;
            ebs_nxt = EBS_RST[NBLK-1:0];
        end
        // Pulses follow their bits; write enable, error and protection gate them
        pp_nxt    = c1_nxt[C1_P] && c1_nxt[C1_SWE] && !err_nxt && !hw_prot &&
                    pg.full;
        ep_nxt    = c1_nxt[C1_E] && c1_nxt[C1_SWE] && !err_nxt && !hw_prot &&
                    !pp_nxt && (ebs_nxt != '0);
        eblk_nxt  = ep_nxt ? ebs_nxt : '0;
        if (pp_nxt) begin
            mode_nxt = FM_PROG;
        end else if (ep_nxt) begin
            mode_nxt = FM_ERASE;
        end else if (c1_nxt[C1_PV]) begin
            mode_nxt = FM_PVER;
        end else if (c1_nxt[C1_EV]) begin
            mode_nxt = FM_EVER;
        end else begin
            mode_nxt = FM_READ;
        end
        irqb_nxt  = pp_nxt || ep_nxt || boot_run_i;
        in_verify = mode_r == FM_PVER || mode_r == FM_EVER;
        dummy_wr  = flash_wr_i && in_verify && flash_wdata_i == DUMMY_BYTE &&
                    flash_addr_i[1:0] == VER_ALIGN;
        varm_nxt  = varm_r;
        vaddr_nxt = vaddr_r;
        if (dummy_wr) begin
            varm_nxt  = 1'b1;
            vaddr_nxt = flash_addr_i;
        end else if (mode_nxt != FM_PVER && mode_nxt != FM_EVER) begin
            varm_nxt  = 1'b0;
        end
        vval_nxt  = flash_rd_i && varm_r && in_verify;
        vdat_nxt  = vval_nxt ? array_rdata_i : vdat_r;
        // Page bytes are taken only while writing is enabled and no mode is set
        pg.load   = flash_wr_i && c1_r[C1_SWE] && mode_r == FM_READ &&
                    !c1_r[C1_P] && !err_r;
        pg.clear  = hw_prot || (pp_r && !pp_nxt);
        pg.addr   = flash_addr_i;
        pg.data   = flash_wdata_i;
        pg.rd_idx = page_rd_idx_i;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            c1_r    <= C1_RST;
            err_r   <= C2_RST[C2_ERR];
            ebs_r   <= EBS_RST[NBLK-1:0];
            pds_r   <= PWR_RST[PWR_PDS];
            mode_r  <= FM_READ;
            pp_r    <= 1'b0;
            ep_r    <= 1'b0;
            eblk_r  <= '0;
            irqb_r  <= 1'b0;
            varm_r  <= 1'b0;
            vaddr_r <= '0;
            vval_r  <= 1'b0;
            vdat_r  <= 32'h0000_0000;
        end else begin
            c1_r    <= c1_nxt;
            err_r   <= err_nxt;
            ebs_r   <= ebs_nxt;
            pds_r   <= pds_nxt;
            mode_r  <= mode_nxt;
            pp_r    <= pp_nxt;
            ep_r    <= ep_nxt;
            eblk_r  <= eblk_nxt;
            irqb_r  <= irqb_nxt;
            varm_r  <= varm_nxt;
            vaddr_r <= vaddr_nxt;
            vval_r  <= vval_nxt;
            vdat_r  <= vdat_nxt;
        end
    end

    fpec_page_latch #(.DEPTH(PAGE_BYTES)) u_page (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .pg       (pg.latch)
    );

    fpec_power_state u_power (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .lsi_mode_i (lsi_mode_i),
        .pds_i      (pds_r),
        .fstate_o   (flash_state_o)
    );

    assign flash_control_one_o   = c1_r;
    assign flash_control_two_o   = {err_r, 7'h00};
    assign erase_block_select_o  = ebs_r;
    assign flash_power_control_o = {pds_r, 7'h00};
    assign flash_mode_o          = mode_r;
    assign program_pulse_o       = pp_r;
    assign erase_pulse_o         = ep_r;
    assign erase_blocks_o        = eblk_r;
    assign page_addr_o           = pg.base;
    assign page_rd_data_o        = pg.rd_data;
    assign irq_block_o           = irqb_r;
    assign verify_armed_o        = varm_r;
    assign verify_addr_o         = vaddr_r;
    assign verify_valid_o        = vval_r;
    assign verify_data_o         = vdat_r;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    one_mode_a: assert property (!(pp_r && ep_r) &&
        (pp_r == (mode_r == FM_PROG)) && (ep_r == (mode_r == FM_ERASE)))
        else $error("flash in more than one mode");
    pulse_follow_a: assert property ($fell(c1_r[C1_P]) |-> !pp_r)
        else $error("program pulse outlived its bit");
    swe_guard_a: assert property (pp_r || ep_r |-> c1_r[C1_SWE])
        else $error("pulse without software write enable");
    block_guard_a: assert property ((eblk_r & ~ebs_r) == '0)
        else $error("erase reached an unselected block");
    err_catch_a: assert property ((pp_r || ep_r) && flash_rd_i |=>
        err_r && !pp_r && !ep_r)
        else $error("flash read during pulse not flagged");
    err_stick_a: assert property (err_r |=> err_r && !pp_r && !ep_r)
        else $error("error state left or pulse restarted");
    err_verify_a: assert property (err_r && c1_wr_i && c1_wdata_i[C1_PV] && !hw_prot
        |=> mode_r == FM_PVER) else $error("verify unreachable in error");
    irq_block_a: assert property (pp_r || ep_r || $past(boot_run_i) |-> irqb_r)
        else $error("interrupts open during program or erase");
    hw_clear_a: assert property (sys_reset_i |=>
        c1_r == C1_RST && ebs_r == '0 && !pp_r)
        else $error("hardware protection left registers set");
    verify_arm_a: assert property (dummy_wr |=> varm_r && vaddr_r[1:0] == VER_ALIGN)
        else $error("dummy write did not arm verify");
endmodule // fpec_flash_control

// *** inc/fpec_pkg.sv ***
// Package for the flash program/erase control block: bit positions, reset values, modes.
// Assumes a single 200 MHz system clock domain.
package fpec_pkg;
    localparam int          DATA_W      = 8;
    localparam int          ADDR_W      = 16;
    localparam int          PAGE_BYTES  = 128;
    localparam int          PAGE_IW     = 7;
    localparam int          BLOCKS      = 8;
    // Flash control one fields
    localparam int          C1_P        = 0;
    localparam int          C1_E        = 1;
    localparam int          C1_PV       = 2;
    localparam int          C1_EV       = 3;
    localparam int          C1_SWE      = 6;
    // Flash control two field
    localparam int          C2_ERR      = 7;
    // Flash power control field
    localparam int          PWR_PDS     = 7;
    localparam logic [7:0]  C1_RST      = 8'h00;
    localparam logic [7:0]  C2_RST      = 8'h00;
    localparam logic [7:0]  EBS_RST     = 8'h00;
    localparam logic [7:0]  PWR_RST     = 8'h00;
    localparam logic [7:0]  DUMMY_BYTE  = 8'hFF;
    localparam logic [1:0]  VER_ALIGN   = 2'h0;
    localparam logic [7:0]  CNT_FULL    = 8'h80;

    typedef enum logic [2:0] {
        FM_READ  = 3'h0,
        FM_PROG  = 3'h1,
        FM_PVER  = 3'h3,
        FM_ERASE = 3'h2,
        FM_EVER  = 3'h6
    } fpec_mode_type;

    typedef enum logic [2:0] {
        LSI_ACTIVE   = 3'h0,
        LSI_SLEEP    = 3'h1,
        LSI_SUBACT   = 3'h3,
        LSI_SUBSLEEP = 3'h2,
        LSI_STANDBY  = 3'h6
    } fpec_lsi_type;

    typedef enum logic [1:0] {
        FS_NORMAL  = 2'h0,
        FS_PDOWN   = 2'h1,
        FS_STANDBY = 2'h3
    } fpec_fstate_type;
endpackage

// *** inc/fpec_page_if.sv ***
// Carrier between the controller and the 128-byte page latch.
// Assumes both ends share clk_i.
`timescale 1ns/100ps
interface fpec_page_if #(parameter int AW = 16, parameter int IW = 7);
    logic          load;
    logic          clear;
    logic [AW-1:0] addr;
    logic [7:0]    data;
    logic [IW-1:0] rd_idx;
    logic          full;
    logic [AW-1:0] base;
    logic [7:0]    rd_data;
    modport ctrl  (output load, clear, addr, data, rd_idx, input full, base, rd_data);
    modport latch (input load, clear, addr, data, rd_idx, output full, base, rd_data);
endinterface

// *** logic/fpec_page_latch.sv ***
// Page latch: collects consecutive byte writes of one program page and its address.
// Assumes the controller raises load only while programming data may be latched.
`timescale 1ns/100ps
module fpec_page_latch
    import fpec_pkg::*;
#(
    parameter int DEPTH = fpec_pkg::PAGE_BYTES
) (
    input  wire logic   clk_i,
    input  wire logic   resetn_i,
    fpec_page_if.latch  pg
);
    logic [7:0]        cnt_r;
    logic [7:0]        cnt_nxt;
    logic [ADDR_W-1:0] base_r;
    logic [ADDR_W-1:0] base_nxt;
    logic [7:0]        rdat_r;
    logic [7:0]        mem [DEPTH];

    always_comb begin
        cnt_nxt  = cnt_r;
        base_nxt = base_r;
        if (pg.clear) begin
            cnt_nxt = 8'h00;
        end else if (pg.load && cnt_r != CNT_FULL) begin
            // Page start keeps only the page-aligned part of the first address
            if (cnt_r == 8'h00) begin
                base_nxt = {pg.addr[ADDR_W-1:PAGE_IW], {PAGE_IW{1'b0}}};
            end
            cnt_nxt = cnt_r + 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r  <= 8'h00;
            base_r <= '0;
            rdat_r <= 8'h00;
        end else begin
            cnt_r  <= cnt_nxt;
            base_r <= base_nxt;
            rdat_r <= mem[pg.rd_idx];
        end
    end

    always_ff @(posedge clk_i) begin
        if (pg.load && !pg.clear && cnt_r != CNT_FULL) begin
            mem[pg.addr[PAGE_IW-1:0]] <= pg.data;
        end
    end

    assign pg.full    = (cnt_r == CNT_FULL);
    assign pg.base    = base_r;
    assign pg.rd_data = rdat_r;

    page_count_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        cnt_r <= CNT_FULL) else $error("page byte count past one page");
endmodule // fpec_page_latch

// *** logic/fpec_power_state.sv ***
// Maps the chip operating state and the power-down select onto the flash state.
// Assumes the operating state input is already synchronous to clk_i.
`timescale 1ns/100ps
module fpec_power_state
    import fpec_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            resetn_i,
    input  fpec_pkg::fpec_lsi_type lsi_mode_i,
    input  wire logic            pds_i,
    output fpec_pkg::fpec_fstate_type fstate_o
);
    fpec_fstate_type fs_r;
    fpec_fstate_type fs_nxt;

    always_comb begin
        unique case (lsi_mode_i)
            LSI_ACTIVE,
            LSI_SLEEP:    fs_nxt = FS_NORMAL;
            LSI_SUBACT:   fs_nxt = pds_i ? FS_NORMAL : FS_PDOWN;
            LSI_SUBSLEEP,
            LSI_STANDBY:  fs_nxt = FS_STANDBY;
            default:      fs_nxt = FS_STANDBY;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fs_r <= FS_NORMAL;
        end else begin
            fs_r <= fs_nxt;
        end
    end

    assign fstate_o = fs_r;

    subact_pdown_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (lsi_mode_i == LSI_SUBACT && !pds_i) |=> fs_r == FS_PDOWN)
        else $error("subactive without select did not power down flash");
endmodule // fpec_power_state

// *** testbench/fpec_cpu_model.sv ***
// CPU model running the program/erase firmware from RAM.
// Assumes one bench process calls its tasks; it drives just after the falling edge of clk_i.
`timescale 1ns/100ps
module fpec_cpu_model
    import fpec_pkg::*;
#(
    parameter int PROG_CYC = 6000,
    parameter int WAKE_CYC = 20000
) (
    input  wire logic                   clk_i,
    input  wire logic [31:0]            vdata_i,
    output logic [6:0]                  stb_o,
    output logic [fpec_pkg::ADDR_W-1:0] addr_o,
    output logic [7:0]                  wd_o
);
    localparam int WDT_PROG  = 1320000;
    localparam int WDT_ERASE = 3960000;
    localparam int MAX_ERASE = 100;
    localparam int MAX_PROG  = 1000;

    initial begin
        stb_o  = 7'h00;
        addr_o = 16'h0000;
        wd_o   = 8'h00;
    end

    // Ops: 0 control one, 1 block select, 2 power, 3 flash write, 4 flash read,
    // 5 exception, 6 sleep
    task automatic cpu_op(input int k, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wd_o   = d;
        stb_o  = 7'h01 << k;
        @(negedge clk_i);
        stb_o  = 7'h00;
        wd_o   = ~d;
    endtask

    // Whole page, one byte a cycle, from an aligned base of an erased page
    task automatic load_page(input logic [15:0] base);
        @(negedge clk_i);
        stb_o = 7'h08;
        for (int i = 0; i < PAGE_BYTES; i++) begin
            addr_o = base + 16'(i);
            wd_o   = 8'(i);
            @(negedge clk_i);
        end
        stb_o = 7'h00;
        wd_o  = 8'h55;
    endtask

    // Pulse held by software, kept short of the watchdog overflow
    task automatic hold_pulse(input int cyc, input logic erase);
        if (cyc < (erase ? WDT_ERASE : WDT_PROG)) begin
            repeat (cyc) @(negedge clk_i);
        end
    endtask

    function automatic logic [7:0] reprog(input logic [7:0] pd, input logic [7:0] vd);
        return pd | ~vd;
    endfunction

    function automatic logic [7:0] addprog(input logic [7:0] rp, input logic [7:0] vd);
        return rp | vd;
    endfunction

    // Program pulse cycles for write attempt n; none past the pass limit
    function automatic int prog_cycles(input int n, input logic extra);
        if (n > MAX_PROG) begin
            return 0;
        end
        return extra ? PROG_CYC / 3 : (n <= 6) ? PROG_CYC : PROG_CYC * 20 / 3;
    endfunction

    // One block a pass, erase and verify repeated a bounded number of times
    task automatic erase_block(input int blk, output int tries);
        tries = 0;
        cpu_op(1, 16'h0000, 8'h01 << blk);
        do begin
            tries++;
            cpu_op(0, 16'h0000, 8'h42);
            hold_pulse(40, 1'b1);
            cpu_op(0, 16'h0000, 8'h40);
            cpu_op(0, 16'h0000, 8'h48);
            cpu_op(3, 16'h0000, DUMMY_BYTE);
            cpu_op(4, 16'h0000, 8'h00);
        end while (vdata_i !== 32'hFFFF_FFFF && tries < MAX_ERASE);
        cpu_op(0, 16'h0000, 8'h40);
        cpu_op(1, 16'h0000, 8'h00);
    endtask

    // Stabilisation wait before normal flash use
    task automatic wake_wait;
        repeat (WAKE_CYC) @(negedge clk_i);
    endtask
endmodule // fpec_cpu_model

// *** testbench/tb_flash_program_erase_control.sv ***
// Self-checking bench for the flash program/erase controller.
// Assumes the CPU model drives the strobes; the bench drives resets and chip state.
`timescale 1ns/100ps
module tb_flash_program_erase_control;
    import fpec_pkg::*;
    typedef struct packed {
        logic [7:0]    c1;
        logic [7:0]    ebs;
        fpec_mode_type mode;
        logic          ep;
    } fpec_row_type;
    localparam fpec_row_type ROWS [7] = '{
        '{8'h44, 8'h00, FM_PVER, 1'b0}, '{8'h48, 8'h00, FM_EVER, 1'b0},
        '{8'h42, 8'h01, FM_ERASE, 1'b1}, '{8'h42, 8'h80, FM_ERASE, 1'b1},
        '{8'h02, 8'h01, FM_READ, 1'b0}, '{8'h42, 8'h00, FM_READ, 1'b0},
        '{8'h00, 8'h00, FM_READ, 1'b0}};
    localparam fpec_lsi_type LSI [5] = '{LSI_ACTIVE, LSI_SLEEP, LSI_SUBACT, LSI_SUBSLEEP,
                                         LSI_STANDBY};
    logic            clk_i = 1'b0;
    logic            resetn_i = 1'b0;
    logic            sys_reset_i = 1'b0;
    logic            boot_run_i = 1'b0;
    fpec_lsi_type    lsi_mode_i = LSI_ACTIVE;
    logic [31:0]     array_rdata_i = 32'h0000_0000;
    logic [6:0]      page_rd_idx_i = 7'h00;
    logic [6:0]      stb;
    logic [15:0]     cpu_a, pa_o, va_o;
    logic [7:0]      cpu_d, c1_o, c2_o, ebs_o, pwr_o, eblk_o, prd_o, seen = 8'h00;
    logic            pp_o, ep_o, irq_o, varm_o, vval_o;
    logic [31:0]     vd_o;
    fpec_mode_type   mode_o;
    fpec_fstate_type fs_o, fs_exp;
    int              failures = 0;
    int              num_checks = 0;
    int              tries;

    always #2.5 clk_i = ~clk_i;
    // Blocks seen under erase since the last power-on reset
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            seen <= 8'h00;
        end else if (ep_o === 1'b1) begin
            seen <= seen | eblk_o;
        end
    end

    fpec_cpu_model i_cpu (.clk_i(clk_i), .vdata_i(vd_o), .stb_o(stb), .addr_o(cpu_a),
                          .wd_o(cpu_d));

    fpec_flash_control i_dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .sys_reset_i(sys_reset_i),
        .lsi_mode_i(lsi_mode_i), .boot_run_i(boot_run_i), .exception_i(stb[5]),
        .sleep_i(stb[6]), .c1_wr_i(stb[0]), .c1_wdata_i(cpu_d), .ebs_wr_i(stb[1]),
        .ebs_wdata_i(cpu_d), .pwr_wr_i(stb[2]), .pwr_wdata_i(cpu_d), .flash_wr_i(stb[3]),
        .flash_rd_i(stb[4]), .flash_addr_i(cpu_a), .flash_wdata_i(cpu_d),
        .array_rdata_i(array_rdata_i), .page_rd_idx_i(page_rd_idx_i),
        .flash_control_one_o(c1_o), .flash_control_two_o(c2_o), .erase_block_select_o(ebs_o),
        .flash_power_control_o(pwr_o), .flash_mode_o(mode_o), .program_pulse_o(pp_o),
        .erase_pulse_o(ep_o), .erase_blocks_o(eblk_o), .page_addr_o(pa_o),
        .page_rd_data_o(prd_o), .irq_block_o(irq_o), .verify_armed_o(varm_o),
        .verify_addr_o(va_o), .verify_valid_o(vval_o), .verify_data_o(vd_o),
        .flash_state_o(fs_o));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic por;
        @(negedge clk_i);
        resetn_i = 1'b0;
        repeat (10) @(negedge clk_i);
        resetn_i = 1'b1;
    endtask

    initial begin
        #400000;
        failures++;
        tally_and_finish();
    end

    initial begin
        por();
        chk({c1_o, c2_o, ebs_o, pwr_o}, 32'h0000_0000, "regs after reset");
        chk({mode_o, fs_o, pp_o, ep_o}, {FM_READ, FS_NORMAL, 2'b00}, "state after reset");
        foreach (ROWS[i]) begin
            i_cpu.cpu_op(1, 16'h0000, ROWS[i].ebs);
            i_cpu.cpu_op(0, 16'h0000, ROWS[i].c1);
            chk(c1_o, ROWS[i].c1, "control one");
            chk(mode_o, ROWS[i].mode, "mode");
            chk(ep_o, ROWS[i].ep, "erase pulse");
            chk(eblk_o, ROWS[i].ep ? ROWS[i].ebs : 8'h00, "erase blocks");
        end
        // Program: refused on empty page, then a full page, verify with aligned dummy after a misaligned one
        i_cpu.cpu_op(0, 16'h0000, 8'h41);
        chk(pp_o, 1'b0, "pulse without page");
        i_cpu.cpu_op(0, 16'h0000, 8'h40);
        i_cpu.load_page(16'h1280);
        chk(pa_o, 16'h1280, "page base");
        page_rd_idx_i = 7'h05;
        @(negedge clk_i);
        chk(prd_o, 8'h05, "latched byte");
        i_cpu.cpu_op(0, 16'h0000, 8'h41);
        chk({pp_o, mode_o, irq_o}, {1'b1, FM_PROG, 1'b1}, "program on");
        i_cpu.hold_pulse(i_cpu.prog_cycles(1, 1'b0) - 2, 1'b0);
        chk(pp_o, 1'b1, "pulse held");
        i_cpu.cpu_op(0, 16'h0000, 8'h40);
        chk(pp_o, 1'b0, "pulse off");
        @(negedge clk_i);
        chk(irq_o, 1'b0, "irq block off");
        i_cpu.cpu_op(0, 16'h0000, 8'h44);
        array_rdata_i = 32'h1234_5678;
        i_cpu.cpu_op(3, 16'h1286, DUMMY_BYTE);
        chk(varm_o, 1'b0, "misaligned dummy");
        i_cpu.cpu_op(3, 16'h1284, DUMMY_BYTE);
        chk({varm_o, va_o}, {1'b1, 16'h1284}, "dummy write");
        i_cpu.cpu_op(4, 16'h1284, 8'h00);
        chk({vval_o, vd_o}, {1'b1, 32'h1234_5678}, "verify read");
        chk(i_cpu.reprog(8'h0F, vd_o[7:0]), 8'h8F, "reprogram data");
        chk(i_cpu.addprog(8'h05, vd_o[7:0]), 8'h7D, "additional data");
        @(negedge clk_i);
        chk(vval_o, 1'b0, "verify pulse one cycle");
        // Errors by flash read, exception and sleep during erase
        for (int k = 0; k < 3; k++) begin
            por();
            i_cpu.cpu_op(1, 16'h0000, 8'h04);
            i_cpu.cpu_op(0, 16'h0000, 8'h42);
            chk(eblk_o, 8'h04, "erasing block");
            i_cpu.cpu_op(4 + k, 16'h0000, 8'h00);
            chk({c2_o, c1_o, ep_o}, {16'h8042, 1'b0}, "error stop");
            i_cpu.cpu_op(0, 16'h0000, 8'h42);
            chk(ep_o, 1'b0, "no restart");
        end
        i_cpu.cpu_op(0, 16'h0000, 8'h48);
        chk(mode_o, FM_EVER, "verify in error");
        @(negedge clk_i);
        sys_reset_i = 1'b1;
        @(negedge clk_i);
        sys_reset_i = 1'b0;
        chk({c1_o, ebs_o, c2_o}, 24'h00_0080, "protect keeps flag");
        por();
        chk(c2_o, 8'h00, "flag cleared");
        boot_run_i = 1'b1;
        @(negedge clk_i);
        chk(irq_o, 1'b1, "boot irq block");
        boot_run_i = 1'b0;
        // Erase through the model, then abort by subactive entry
        i_cpu.cpu_op(0, 16'h0000, 8'h40);
        array_rdata_i = 32'hFFFF_FFFF;
        i_cpu.erase_block(2, tries);
        chk(32'(tries), 32'h1, "erase passes");
        chk({seen, ebs_o}, 16'h0400, "single block");
        array_rdata_i = 32'h0000_0000;
        i_cpu.erase_block(3, tries);
        chk(32'(tries), 32'd100, "erase pass limit");
        i_cpu.cpu_op(1, 16'h0000, 8'h01);
        i_cpu.cpu_op(0, 16'h0000, 8'h42);
        lsi_mode_i = LSI_SUBACT;
        repeat (2) @(negedge clk_i);
        chk({c1_o, ebs_o, 7'h00, ep_o}, 24'h0, "low power abort");
        lsi_mode_i = LSI_ACTIVE;
        for (int p = 0; p < 2; p++) begin
            i_cpu.cpu_op(2, 16'h0000, p ? 8'h80 : 8'h00);
            chk(pwr_o, p ? 8'h80 : 8'h00, "power select");
            foreach (LSI[m]) begin
                lsi_mode_i = LSI[m];
                fs_exp = (m >= 3) ? FS_STANDBY : (m == 2 && p == 0) ? FS_PDOWN : FS_NORMAL;
                @(negedge clk_i);
                chk(fs_o, fs_exp, "flash state");
            end
            lsi_mode_i = LSI_ACTIVE;
            i_cpu.wake_wait();
        end
        tally_and_finish();
    end
endmodule // tb_flash_program_erase_control
